/* File: design/ilb_pkg.sv */
// shared constants and types for the led brightness serial slave
`default_nettype none
package ilb_pkg;
   localparam logic [6:0] SLAVE_ADDR        = 7'h5a; // arbitrary value, not a real part address
   localparam logic [7:0] OFS_GENERAL       = 8'h10;
   localparam logic [7:0] OFS_BANK_LEVEL    = 8'ha0;
   localparam logic [7:0] OFS_KEYPAD_LEVEL  = 8'hb0;
   localparam logic [7:0] RST_GENERAL       = 8'h00;
   localparam logic [7:0] RST_BANK_LEVEL    = 8'h00;
   localparam logic [7:0] RST_KEYPAD_LEVEL  = 8'h00;
   localparam int         POS_MAIN_ON       = 0;
   localparam int         POS_SUB_ON        = 1;
   localparam int         POS_KEYPAD_ON     = 2;
   localparam int         POS_MAIN_LEVEL    = 0;
   localparam int         POS_SUB_LEVEL     = 4;
   localparam int         POS_KEYPAD_LEVEL  = 0;
   localparam int         CLK_HZ            = 20_000_000;
   localparam int         PWM_HZ_OPT_LOW    = 10_000;
   localparam int         PWM_HZ_OPT_HIGH   = 23_000;
   localparam int         PWM_STEPS         = 16;
   // cycles per pwm slot, rounded down so the period never runs long
   localparam int         SLOT_CYC_LOW      = CLK_HZ / (PWM_HZ_OPT_LOW * PWM_STEPS);
   localparam int         SLOT_CYC_HIGH     = CLK_HZ / (PWM_HZ_OPT_HIGH * PWM_STEPS);
   localparam logic [6:0] KEY_PCT_FULL      = 7'h64;
   localparam logic [6:0] KEY_PCT_70        = 7'h46;
   localparam logic [6:0] KEY_PCT_40        = 7'h28;
   localparam logic [6:0] KEY_PCT_20        = 7'h14;

   typedef struct packed {
      logic       keypad_sink_on;
      logic       sub_bank_on;
      logic       main_bank_on;
      logic [3:0] main_bank_level_field;
      logic [3:0] sub_bank_level_field;
      logic [1:0] keypad_level_field;
   } ilb_ctrl_t;

   typedef struct packed {
      logic main_display_sinks;
      logic sub_display_sinks;
      logic [6:0] keypad_pct;
      logic pump_gain_3_2;
   } ilb_drive_t;
endpackage
`default_nettype wire

/* File: design/ilb_pwm.sv */
// sixteen-step pwm for one display bank
`default_nettype none
module ilb_pwm #(
   parameter int SLOT_CYC = 125
) (
   input  wire logic       i_clk,   // core clock
   input  wire logic       i_rst,   // sync reset
   input  wire logic       i_on,    // bank enable
   input  wire logic [3:0] i_level, // duty code
   input  wire logic [3:0] i_phase, // shared slot phase
   output logic            o_drive  // sink gate
);
   // code n keeps the sinks on for n+1 of 16 slots
   wire logic drive_next = i_on && (i_phase <= i_level);
   always_ff @(posedge i_clk) begin
      if (i_rst) o_drive <= 1'b0;
      else       o_drive <= drive_next;
   end
endmodule
`default_nettype wire

/* File: design/ilb_phase.sv */
// fixed-rate slot counter shared by both display banks
`default_nettype none
module ilb_phase #(
   parameter int SLOT_CYC = 125
) (
   input  wire logic       i_clk,  // core clock
   input  wire logic       i_rst,  // sync reset
   output logic [3:0]      o_phase // current slot 0..15
);
   logic [15:0] cnt_reg;
   wire  logic  slot_end = (cnt_reg == 16'(SLOT_CYC - 1));
   // rate set only by the build option, never by registers
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_reg <= 16'h0000;
         o_phase <= 4'h0;
      end else if (slot_end) begin
         cnt_reg <= 16'h0000;
         o_phase <= o_phase + 4'h1;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end
endmodule
`default_nettype wire

/* File: design/ilb_top.sv */
// serial-bus slave, register file and sink control for the led driver
`default_nettype none
// Functional notes
// - data stable while bus clock high
// - data falling with clock high starts
// - data rising with clock high stops
// - repeated start restarts address reception
// - eight bits msb first plus ack
// - slave pulls data low on ninth pulse
// - acknowledge address, select and data bytes
// - first byte: seven-bit address, direction bit
// - second byte register, third byte data
// - three eight-bit registers, reset zero
// - general register: three bank enables
// - level register: two four-bit fields
// - each display step is one sixteenth
// - keypad code three is full scale
// - keypad upper six bits ignored
// - keypad has four intensity steps
// - display banks dimmed by sixteen-step pwm
// - pwm rate fixed by product option
// - keypad dims by analog level
// - keypad alone forces pump gain 3/2
// - headroom watch only enabled display banks
module ilb_top #(
   parameter bit FAST_OPTION = 1'b0  // 0: low pwm rate, 1: high pwm rate
) (
   input  wire logic       I_CORE_CLK,      // core clock 20 mhz
   input  wire logic       I_SYS_RST,       // sync reset, active high
   input  wire logic       I_SCL,           // bus clock pin
   input  wire logic       I_SDA,           // bus data pin level
   input  wire logic       I_HEADROOM_LOW,  // a watched display sink lacks headroom
   output logic            O_SDA,           // data drive value, always low
   output logic            O_SDA_OE,        // high while pulling data low
   output logic            O_MAIN_SINKS,    // main display sinks gate
   output logic            O_SUB_SINKS,     // sub display sinks gate
   output logic            O_KEYPAD_ON,     // keypad sink enabled
   output logic [6:0]      O_KEYPAD_PCT,    // keypad analog level, percent
   output logic            O_PUMP_GAIN_3_2, // pump gain select 3/2
   output logic            O_WATCH_MAIN,    // headroom watch on main sinks
   output logic            O_WATCH_SUB,     // headroom watch on sub sinks
   output logic            O_BUS_BUSY       // between start and stop
);
   localparam int SLOT_CYC = FAST_OPTION ? ilb_pkg::SLOT_CYC_HIGH : ilb_pkg::SLOT_CYC_LOW;

   typedef enum logic [2:0] {IDLE, ADDR, REG, DATA, ACK, IGNORE} ilb_state_t;

   // two-flop synchronisers; stage one feeds only stage two
   logic scl_s1_reg, scl_s2_reg, scl_d_reg;
   logic sda_s1_reg, sda_s2_reg, sda_d_reg;
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_d_reg  <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_d_reg  <= 1'b1;
      end else begin
         scl_s1_reg <= I_SCL;
         scl_s2_reg <= scl_s1_reg;
         scl_d_reg  <= scl_s2_reg;
         sda_s1_reg <= I_SDA;
         sda_s2_reg <= sda_s1_reg;
         sda_d_reg  <= sda_s2_reg;
      end
   end

   wire logic scl_rise = scl_s2_reg & ~scl_d_reg;
   wire logic scl_fall = ~scl_s2_reg & scl_d_reg;
   wire logic start_ev = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
   wire logic stop_ev  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

   ilb_state_t state_reg, state_next, after_ack_reg, after_ack_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] sel_reg, sel_next;
   logic       ack_drv_reg, ack_drv_next;
   logic       wr_en_reg, wr_en_next;
   logic       busy_reg;

   logic [7:0] general_enable_reg;
   logic [7:0] display_bank_level_reg;
   logic [7:0] keypad_level_reg;

   // data is sampled only on clock rise, so changes while clock is low are the legal ones
   wire logic [7:0] byte_in = {shift_reg[6:0], sda_s2_reg};
   wire logic       last_bit = (bit_cnt_reg == 3'h7);
   wire logic       addr_hit = (byte_in[7:1] == ilb_pkg::SLAVE_ADDR) && !byte_in[0];

   always_comb begin
      state_next     = state_reg;
      after_ack_next = after_ack_reg;
      bit_cnt_next   = bit_cnt_reg;
      shift_next     = shift_reg;
      sel_next       = sel_reg;
      ack_drv_next   = ack_drv_reg;
      wr_en_next     = 1'b0;
      if (start_ev) begin
         // a repeated start is handled the same as the first
         state_next   = ADDR;
         bit_cnt_next = 3'h0;
         ack_drv_next = 1'b0;
      end else if (stop_ev) begin
         state_next   = IDLE;
         ack_drv_next = 1'b0;
      end else begin
         unique case (state_reg)
            IDLE, IGNORE: begin
            end
            ADDR, REG, DATA: begin
               if (scl_rise) begin
                  shift_next   = byte_in;
                  bit_cnt_next = bit_cnt_reg + 3'h1;
               end
               if (scl_rise && last_bit) begin
                  unique case (state_reg)
                     ADDR: after_ack_next = addr_hit ? REG : IGNORE;
                     REG: begin
                        sel_next       = byte_in;
                        after_ack_next = DATA;
                     end
                     default: begin
                        wr_en_next     = 1'b1;
                        after_ack_next = DATA;
                     end
                  endcase
                  state_next = ACK;
               end
            end
            ACK: begin
               // drive low after the eighth clock falls, release after the ninth falls
               if (scl_fall && !ack_drv_reg && after_ack_reg != IGNORE)
                  ack_drv_next = 1'b1;
               else if (scl_fall && ack_drv_reg) begin
                  ack_drv_next = 1'b0;
                  state_next   = after_ack_reg;
                  bit_cnt_next = 3'h0;
               end else if (scl_fall && after_ack_reg == IGNORE)
                  state_next = IGNORE;
            end
            default: state_next = IDLE;
         endcase
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         state_reg     <= IDLE;
         after_ack_reg <= IDLE;
         bit_cnt_reg   <= 3'h0;
         shift_reg     <= 8'h00;
         sel_reg       <= 8'h00;
         ack_drv_reg   <= 1'b0;
         wr_en_reg     <= 1'b0;
      end else begin
         state_reg     <= state_next;
         after_ack_reg <= after_ack_next;
         bit_cnt_reg   <= bit_cnt_next;
         shift_reg     <= shift_next;
         sel_reg       <= sel_next;
         ack_drv_reg   <= ack_drv_next;
         wr_en_reg     <= wr_en_next;
      end
   end

   // master owns framing; we only track it
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST)     busy_reg <= 1'b0;
      else if (start_ev) busy_reg <= 1'b1;
      else if (stop_ev)  busy_reg <= 1'b0;
   end

   // register writes land one cycle after the data byte's last bit
   wire logic hit_gen = wr_en_reg && (sel_reg == ilb_pkg::OFS_GENERAL);
   wire logic hit_lvl = wr_en_reg && (sel_reg == ilb_pkg::OFS_BANK_LEVEL);
   wire logic hit_key = wr_en_reg && (sel_reg == ilb_pkg::OFS_KEYPAD_LEVEL);
   // any other select matches none and is dropped after its ack
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         general_enable_reg     <= ilb_pkg::RST_GENERAL;
         display_bank_level_reg <= ilb_pkg::RST_BANK_LEVEL;
         keypad_level_reg       <= ilb_pkg::RST_KEYPAD_LEVEL;
      end else begin
         if (hit_gen) general_enable_reg     <= shift_reg;
         if (hit_lvl) display_bank_level_reg <= shift_reg;
         if (hit_key) keypad_level_reg       <= shift_reg;
      end
   end

   ilb_pkg::ilb_ctrl_t ctrl;
   assign ctrl.main_bank_on          = general_enable_reg[ilb_pkg::POS_MAIN_ON];
   assign ctrl.sub_bank_on           = general_enable_reg[ilb_pkg::POS_SUB_ON];
   assign ctrl.keypad_sink_on        = general_enable_reg[ilb_pkg::POS_KEYPAD_ON];
   assign ctrl.main_bank_level_field = display_bank_level_reg[ilb_pkg::POS_MAIN_LEVEL +: 4];
   assign ctrl.sub_bank_level_field  = display_bank_level_reg[ilb_pkg::POS_SUB_LEVEL +: 4];
   // upper keypad bits are stored but never looked at
   assign ctrl.keypad_level_field    = keypad_level_reg[ilb_pkg::POS_KEYPAD_LEVEL +: 2];

   function automatic logic [6:0] key_pct(input logic [1:0] code);
      unique case (code)
         2'h3: key_pct = ilb_pkg::KEY_PCT_FULL;
         2'h2: key_pct = ilb_pkg::KEY_PCT_70;
         2'h1: key_pct = ilb_pkg::KEY_PCT_40;
         2'h0: key_pct = ilb_pkg::KEY_PCT_20;
      endcase
   endfunction

   logic [3:0] phase;
   logic       main_pwm, sub_pwm;

   ilb_phase #(.SLOT_CYC(SLOT_CYC)) u_phase (
      .i_clk   (I_CORE_CLK),
      .i_rst   (I_SYS_RST),
      .o_phase (phase)
   );
   ilb_pwm #(.SLOT_CYC(SLOT_CYC)) u_main_pwm (
      .i_clk   (I_CORE_CLK),
      .i_rst   (I_SYS_RST),
      .i_on    (ctrl.main_bank_on),
      .i_level (ctrl.main_bank_level_field),
      .i_phase (phase),
      .o_drive (main_pwm)
   );
   ilb_pwm #(.SLOT_CYC(SLOT_CYC)) u_sub_pwm (
      .i_clk   (I_CORE_CLK),
      .i_rst   (I_SYS_RST),
      .i_on    (ctrl.sub_bank_on),
      .i_level (ctrl.sub_bank_level_field),
      .i_phase (phase),
      .o_drive (sub_pwm)
   );

   // headroom input is a pin, so it is synchronised too
   logic hr_s1_reg, hr_s2_reg;
   wire logic keypad_alone = ctrl.keypad_sink_on && !ctrl.main_bank_on && !ctrl.sub_bank_on;
   wire logic banks_on     = ctrl.main_bank_on || ctrl.sub_bank_on;
   wire logic gain_next    = keypad_alone || (banks_on && hr_s2_reg);

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         hr_s1_reg       <= 1'b0;
         hr_s2_reg       <= 1'b0;
         O_SDA_OE        <= 1'b0;
         O_MAIN_SINKS    <= 1'b0;
         O_SUB_SINKS     <= 1'b0;
         O_KEYPAD_ON     <= 1'b0;
         O_KEYPAD_PCT    <= ilb_pkg::KEY_PCT_20;
         O_PUMP_GAIN_3_2 <= 1'b0;
         O_WATCH_MAIN    <= 1'b0;
         O_WATCH_SUB     <= 1'b0;
         O_BUS_BUSY      <= 1'b0;
      end else begin
         hr_s1_reg       <= I_HEADROOM_LOW;
         hr_s2_reg       <= hr_s1_reg;
         O_SDA_OE        <= ack_drv_next;
         O_MAIN_SINKS    <= main_pwm;
         O_SUB_SINKS     <= sub_pwm;
         O_KEYPAD_ON     <= ctrl.keypad_sink_on;
         O_KEYPAD_PCT    <= key_pct(ctrl.keypad_level_field);
         O_PUMP_GAIN_3_2 <= gain_next;
         O_WATCH_MAIN    <= ctrl.main_bank_on;
         O_WATCH_SUB     <= ctrl.sub_bank_on;
         O_BUS_BUSY      <= busy_reg;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) O_SDA <= 1'b0;
      else           O_SDA <= 1'b0;
   end
endmodule
`default_nettype wire

/* File: testbench/ilb_top_props.sv */
// port checks for the led brightness serial slave
`default_nettype none
module ilb_top_chk (
   input wire logic I_CORE_CLK,      // clock
   input wire logic I_SYS_RST,       // reset
   input wire logic I_SCL,           // bus clock
   input wire logic I_SDA,           // bus data
   input wire logic I_HEADROOM_LOW,  // headroom
   input wire logic O_SDA_OE,        // ack pull
   input wire logic O_MAIN_SINKS,    // main gate
   input wire logic O_KEYPAD_ON,     // keypad on
   input wire logic O_PUMP_GAIN_3_2, // gain
   input wire logic O_WATCH_MAIN,    // main watch
   input wire logic O_WATCH_SUB,     // sub watch
   input wire logic O_BUS_BUSY       // busy
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SYS_RST);
   property p_start; $fell(I_SDA) && I_SCL && $past(I_SCL) |-> ##[1:6] O_BUS_BUSY; endproperty
   a_start: assert property (p_start) else $error("start missed");
   property p_stop; $rose(I_SDA) && I_SCL && $past(I_SCL) |-> ##[1:6] !O_BUS_BUSY; endproperty
   a_stop: assert property (p_stop) else $error("stop missed");
   property p_oe_low; $changed(O_SDA_OE) |-> !I_SCL && !$past(I_SCL); endproperty
   a_oe_low: assert property (p_oe_low) else $error("ack moved with clock high");
   property p_ack_hold; $rose(I_SCL) && O_SDA_OE |-> O_SDA_OE [*4]; endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
   property p_idle; !O_BUS_BUSY |-> !O_SDA_OE; endproperty
   a_idle: assert property (p_idle) else $error("ack on idle bus");
   property p_kp_alone; (O_KEYPAD_ON && !O_WATCH_MAIN && !O_WATCH_SUB) [*3] |-> O_PUMP_GAIN_3_2; endproperty
   a_kp_alone: assert property (p_kp_alone) else $error("keypad alone without gain");
   property p_hr_gain; (I_HEADROOM_LOW && O_WATCH_SUB) [*5] |-> O_PUMP_GAIN_3_2; endproperty
   a_hr_gain: assert property (p_hr_gain) else $error("headroom ignored");
   property p_main_off; !O_WATCH_MAIN && !$past(O_WATCH_MAIN) && !$past(O_WATCH_MAIN, 2) |-> !O_MAIN_SINKS; endproperty
   a_main_off: assert property (p_main_off) else $error("disabled bank lit");
endmodule
bind ilb_top ilb_top_chk ilb_top_chk_i (.I_CORE_CLK, .I_SYS_RST, .I_SCL, .I_SDA, .I_HEADROOM_LOW, .O_SDA_OE,
   .O_MAIN_SINKS, .O_KEYPAD_ON, .O_PUMP_GAIN_3_2, .O_WATCH_MAIN, .O_WATCH_SUB, .O_BUS_BUSY);
`default_nettype wire

/* File: testbench/ilb_bus_master.sv */
// behavioural two-wire bus master paced by the core clock
`default_nettype none
module ilb_bus_master (
   input  wire logic i_clk,     // pacing clock
   input  wire logic i_sda,     // resolved data
   output logic      o_scl,     // bus clock
   output logic      o_sda_low  // pulls data low
);
   timeunit 1ns;
   timeprecision 100ps;
   int q = 2;  // quarter period; 8 cycles make a 400 ns bus clock
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic tick(input logic c, input logic d);
      repeat (q) @(posedge i_clk);
      #2;
      o_scl = c;
      o_sda_low = d;
   endtask
   task automatic start();  // also serves as a repeated start
      tick(o_scl, 1'b0);
      tick(1'b1, 1'b0);
      tick(1'b1, 1'b1);
      tick(1'b0, 1'b1);
   endtask
   task automatic stop();  // data rises with clock high
      tick(1'b0, 1'b1);
      tick(1'b1, 1'b1);
      tick(1'b1, 1'b0);
      tick(1'b1, 1'b0);
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         tick(1'b0, ~b[i]);  // data moves only with clock low
         tick(1'b1, ~b[i]);
         tick(1'b1, ~b[i]);
         tick(1'b0, ~b[i]);
      end
      tick(1'b0, 1'b0);  // released for the ninth pulse
      tick(1'b1, 1'b0);
      tick(1'b1, 1'b0);
      ack = ~i_sda;
      tick(1'b0, 1'b0);
   endtask
endmodule
`default_nettype wire

/* File: testbench/i2c_led_brightness_ctrl_bench.sv */
// self-checking bench for the led brightness serial slave
`default_nettype none
`define CHK(x, y) begin n_compared++; if ((x) !== (y)) begin error_cnt++; \
   $display("mismatch at %0t: %h vs %h", $time, x, y); end end
module i2c_led_brightness_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] WR  = {ilb_pkg::SLAVE_ADDR, 1'b0};
   localparam logic [7:0] GEN = ilb_pkg::OFS_GENERAL;
   localparam logic [7:0] KEY = ilb_pkg::OFS_KEYPAD_LEVEL;
   localparam int         PER = 16 * ilb_pkg::SLOT_CYC_HIGH;
   logic        clk, rst, hr_low, scl, sda_low, dut_sda, dut_oe;
   logic        main_s, sub_s, kp_on, gain, w_main, w_sub, busy;
   logic [6:0]  kp_pct;
   logic [2:0]  acks;
   logic [7:0]  gen, kp;
   logic [9:0]  c_main, c_sub;
   logic [19:0] e, e2;
   logic [19:0] exp_q[$];
   logic [6:0]  pct_tab[4] = '{7'h14, 7'h28, 7'h46, 7'h64};
   logic [31:0] rnd = 32'hda55;
   int          error_cnt = 0;
   int          n_compared = 0;
   event        chk_ev, duty_ev;
   wire logic   sda = ~(sda_low | (dut_oe & ~dut_sda));  // pull-up unless a party pulls low
   ilb_top #(.FAST_OPTION(1'b1)) ilb_top_i (
      .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_SCL(scl), .I_SDA(sda), .I_HEADROOM_LOW(hr_low),
      .O_SDA(dut_sda), .O_SDA_OE(dut_oe), .O_MAIN_SINKS(main_s), .O_SUB_SINKS(sub_s),
      .O_KEYPAD_ON(kp_on), .O_KEYPAD_PCT(kp_pct), .O_PUMP_GAIN_3_2(gain),
      .O_WATCH_MAIN(w_main), .O_WATCH_SUB(w_sub), .O_BUS_BUSY(busy)
   );
   ilb_bus_master ilb_bus_master_i (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   function automatic logic [10:0] status();
      logic bank;
      bank = gen[0] | gen[1];
      return {gen[2], pct_tab[kp[1:0]], (gen[2] & ~bank) | (bank & hr_low), gen[0], gen[1]};
   endfunction
   task automatic xfer(input logic rs, input logic [7:0] a, input logic [7:0] s, input logic [7:0] d);
      logic       k;
      logic [2:0] ea;
      ea = 3'b000;
      if (a == WR) begin
         ea = 3'b111;
         if (s == GEN) gen = d;
         if (s == KEY) kp = d;
      end
      exp_q.push_back({6'h00, ea, status()});
      if (rs) begin
         ilb_bus_master_i.start();
         ilb_bus_master_i.send(a, k);
         ilb_bus_master_i.send(KEY, k);
      end
      ilb_bus_master_i.start();
      ilb_bus_master_i.send(a, acks[2]);
      `CHK(busy, 1'b1)
      ilb_bus_master_i.send(s, acks[1]);
      ilb_bus_master_i.send(d, acks[0]);
      ilb_bus_master_i.stop();
      repeat (6) @(posedge clk);
      #2;
      ->chk_ev;
   endtask
   task automatic duty(input logic [3:0] m, input logic [3:0] s);
      xfer(1'b0, WR, ilb_pkg::OFS_BANK_LEVEL, {s, m});
      exp_q.push_back({10'(PER / 16 * (m + 1)), 10'(PER / 16 * (s + 1))});
      ->duty_ev;
      repeat (PER + 2) @(posedge clk);
   endtask
   task automatic results();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(chk_ev) begin
      e = exp_q.pop_front();
      `CHK({6'h00, acks, kp_on, kp_pct, gain, w_main, w_sub}, e)
      `CHK({busy, dut_sda}, 2'b00)
   end
   // one full pwm period counted, so the start phase does not matter
   always @(duty_ev) begin
      c_main = 10'h000;
      c_sub = 10'h000;
      repeat (PER) begin
         @(negedge clk);
         c_main = c_main + 10'(main_s);
         c_sub = c_sub + 10'(sub_s);
      end
      e2 = exp_q.pop_front();
      `CHK({c_main, c_sub}, e2)
   end
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      results();
   end
   initial begin
      rst = 1'b1;
      hr_low = 1'b0;
      acks = 3'b000;
      gen = 8'h00;
      kp = 8'h00;
      repeat (16) @(posedge clk);
      #2;
      rst = 1'b0;
      repeat (3) @(posedge clk);
      exp_q.push_back({9'h000, status()});
      ->chk_ev;
      xfer(1'b0, WR, GEN, 8'h04);  // keypad alone
      for (int i = 0; i < 4; i++) begin
         rnd = xs(rnd);
         xfer(1'b0, WR, KEY, {rnd[7:2], 2'(i)});
      end
      xfer(1'b0, WR, GEN, 8'h03);
      hr_low = 1'b1;
      xfer(1'b0, WR, 8'h20, 8'hff);
      hr_low = 1'b0;
      ilb_bus_master_i.q = 30;
      xfer(1'b0, WR ^ 8'h02, GEN, 8'h00);
      xfer(1'b0, WR | 8'h01, GEN, 8'h00);
      ilb_bus_master_i.q = 2;
      xfer(1'b1, WR, GEN, 8'h07);
      duty(4'h0, 4'hf);
      duty(4'hf, 4'h0);
      rnd = xs(rnd);
      duty(rnd[3:0], rnd[7:4]);
      results();
   end
endmodule
`default_nettype wire
